// ===== design/embedded_multiplier_block.sv
// Embedded multiplier block top: fabric datapath and Wishbone configuration registers.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/100ps
module embedded_multiplier_block (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Shared datapath controls.
  input  wire logic                        ena_i,
  input  wire logic                        aclr_i,
  // Operands and sign selects from the fabric.
  input  wire logic [mult_pkg::WIDE_W-1:0] data_a_i,
  input  wire logic [mult_pkg::WIDE_W-1:0] data_b_i,
  input  wire logic                        sign_a_i,
  input  wire logic                        sign_b_i,
  // Products to the fabric.
  output logic      [mult_pkg::PROD_W-1:0] prod_o,
  output logic                             prod_signed_o,
  // Classic Wishbone slave.
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [mult_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [mult_pkg::SEL_W-1:0]  wb_sel_i,
  input  wire logic [mult_pkg::DAT_W-1:0]  wb_dat_i,
  output logic      [mult_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                             wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  mult_pkg::cfg_t                  cfg;
  mult_pkg::opnd_t                 side_a_in;
  mult_pkg::opnd_t                 side_b_in;
  logic [mult_pkg::WIDE_W-1:0]     a_mul;
  logic [mult_pkg::WIDE_W-1:0]     b_mul;
  logic                            sa_mul;
  logic                            sb_mul;
  logic [mult_pkg::PROD_W-1:0]     next_prod;
  logic [mult_pkg::PROD_W-1:0]     prod_q;
  logic                            next_prod_signed;
  logic                            prod_signed_q;
  logic                            aclr_seen;
  logic [mult_pkg::CNT_W-1:0]      accept_cnt;
  logic                            bus_req;
  logic                            bus_wr;
  logic [mult_pkg::DAT_W-1:0]      next_rdata;
  logic [mult_pkg::DAT_W-1:0]      status_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode helper, shared by the read and the write path.

  // Compares the word address only; the two low byte-address bits are ignored.
  function automatic logic reg_hit(input logic [mult_pkg::ADR_W-1:0] adr,
                                   input logic [mult_pkg::ADR_W-1:0] off);
    reg_hit = (adr[mult_pkg::ADR_W-1:2] == off[mult_pkg::ADR_W-1:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Operand and sign select capture.

  // Unused sign selects are forced low, giving an unsigned multiply on both sides.
  assign side_a_in.sign = cfg.sign_use ? sign_a_i : 1'b0;
  assign side_b_in.sign = cfg.sign_use ? sign_b_i : 1'b0;

  // Narrower values of ten to eighteen bits must arrive sign- or zero-extended to 18 bits.
  assign side_a_in.data = data_a_i;
  assign side_b_in.data = data_b_i;

  // Operand A: its own register-or-bypass choice, sharing clock, enable and clear.
  operand_stage #(
    .W         (mult_pkg::WIDE_W)
  ) u_stage_a (
    .clk_i     (clk_i),
    .ena_i     (ena_i),
    .aclr_i    (aclr_i),
    .use_reg_i (cfg.a_reg),
    .d_i       (side_a_in.data),
    .q_o       (a_mul)
  );

  // Operand B: independent of operand A's choice.
  operand_stage #(
    .W         (mult_pkg::WIDE_W)
  ) u_stage_b (
    .clk_i     (clk_i),
    .ena_i     (ena_i),
    .aclr_i    (aclr_i),
    .use_reg_i (cfg.b_reg),
    .d_i       (side_b_in.data),
    .q_o       (b_mul)
  );

  // Sign A has a dedicated register so it can stay aligned with a registered operand A.
  operand_stage #(
    .W         (1)
  ) u_stage_sa (
    .clk_i     (clk_i),
    .ena_i     (ena_i),
    .aclr_i    (aclr_i),
    .use_reg_i (cfg.sa_reg),
    .d_i       (side_a_in.sign),
    .q_o       (sa_mul)
  );

  // Sign B has its own dedicated register as well.
  operand_stage #(
    .W         (1)
  ) u_stage_sb (
    .clk_i     (clk_i),
    .ena_i     (ena_i),
    .aclr_i    (aclr_i),
    .use_reg_i (cfg.sb_reg),
    .d_i       (side_b_in.sign),
    .q_o       (sb_mul)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Multiplier stage.

  // Sign selects are plain inputs to the stage, so a change takes effect on the next product.
  mul_core u_core (
    .dual_i   (cfg.dual),
    .sign_a_i (sa_mul),
    .sign_b_i (sb_mul),
    .a_i      (a_mul),
    .b_i      (b_mul),
    .prod_o   (next_prod)
  );

  // The result is unsigned only when both operands are unsigned.
  assign next_prod_signed = sa_mul | sb_mul;

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers in two 18-bit sections.

  // In single mode both sections load together and act as one 36-bit register.
  for (genvar s = 0; s < mult_pkg::N_SECT; s++) begin : g_sect
    always_ff @(posedge clk_i or posedge aclr_i) begin
      if (aclr_i) begin
        prod_q[s*mult_pkg::SECT_W +: mult_pkg::SECT_W] <= '0;
      end else if (ena_i) begin
        prod_q[s*mult_pkg::SECT_W +: mult_pkg::SECT_W] <=
          next_prod[s*mult_pkg::SECT_W +: mult_pkg::SECT_W];
      end
    end
  end

  // The result-sign flag travels with the product so both change at the same edge.
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      prod_signed_q <= 1'b0;
    end else if (ena_i) begin
      prod_signed_q <= next_prod_signed;
    end
  end

  // Bypassed output is combinational from the operands; registered output costs one edge.
  assign prod_o        = cfg.p_reg ? prod_q : next_prod;
  assign prod_signed_o = cfg.p_reg ? prod_signed_q : next_prod_signed;

  ////////////////////////////////////////////////////////////////////////////////
  // Software-visible state.

  // Counts enabled clock edges; the asynchronous clear also zeroes it.
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      accept_cnt <= '0;
    end else if (rst_i) begin
      accept_cnt <= '0;
    end else if (bus_wr && reg_hit(wb_adr_i, mult_pkg::OFF_COUNT)) begin
      accept_cnt <= '0;
    end else if (ena_i) begin
      accept_cnt <= accept_cnt + 32'h0000_0001;
    end
  end

  // Sticky note that a clear happened; a new clear wins over a software clear.
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      aclr_seen <= 1'b1;
    end else if (rst_i) begin
      aclr_seen <= 1'b0;
    end else if (bus_wr && reg_hit(wb_adr_i, mult_pkg::OFF_STATUS) && wb_sel_i[0] &&
                 wb_dat_i[mult_pkg::STAT_ACLR_BIT]) begin
      aclr_seen <= 1'b0;
    end
  end

  // Status shows the live mode and the signs in use at the multiplier stage.
  always_comb begin
    status_word = '0;
    status_word[mult_pkg::STAT_DUAL_BIT] = cfg.dual;
    status_word[mult_pkg::STAT_SA_BIT]   = sa_mul;
    status_word[mult_pkg::STAT_SB_BIT]   = sb_mul;
    status_word[mult_pkg::STAT_PS_BIT]   = prod_signed_o;
    status_word[mult_pkg::STAT_ACLR_BIT] = aclr_seen;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave.

  // A request is live while cycle and strobe are both high.
  assign bus_req = wb_cyc_i & wb_stb_i;

  // Writes take effect at the edge where the master samples the acknowledge.
  assign bus_wr = bus_req & wb_ack_o & wb_we_i;

  // Acknowledge one cycle after the request, then drop for one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // Configuration lives in byte lane 0; other lanes of the control word are ignored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= mult_pkg::CTRL_RESET;
    end else if (bus_wr && reg_hit(wb_adr_i, mult_pkg::OFF_CTRL) && wb_sel_i[0]) begin
      cfg.dual     <= wb_dat_i[mult_pkg::CTRL_DUAL_BIT];
      cfg.a_reg    <= wb_dat_i[mult_pkg::CTRL_A_REG_BIT];
      cfg.b_reg    <= wb_dat_i[mult_pkg::CTRL_B_REG_BIT];
      cfg.sa_reg   <= wb_dat_i[mult_pkg::CTRL_SA_REG_BIT];
      cfg.sb_reg   <= wb_dat_i[mult_pkg::CTRL_SB_REG_BIT];
      cfg.p_reg    <= wb_dat_i[mult_pkg::CTRL_P_REG_BIT];
      cfg.sign_use <= wb_dat_i[mult_pkg::CTRL_SIGN_BIT];
    end
  end

  // Read data is chosen combinationally; unmapped addresses read as zero.
  always_comb begin
    next_rdata = '0;
    if (reg_hit(wb_adr_i, mult_pkg::OFF_CTRL)) begin
      next_rdata[mult_pkg::CTRL_W-1:0] = cfg;
    end else if (reg_hit(wb_adr_i, mult_pkg::OFF_STATUS)) begin
      next_rdata = status_word;
    end else if (reg_hit(wb_adr_i, mult_pkg::OFF_PROD_LO)) begin
      next_rdata = prod_o[31:0];
    end else if (reg_hit(wb_adr_i, mult_pkg::OFF_PROD_HI)) begin
      next_rdata[3:0] = prod_o[35:32];
    end else if (reg_hit(wb_adr_i, mult_pkg::OFF_OPND_A)) begin
      next_rdata[mult_pkg::WIDE_W-1:0] = a_mul;
    end else if (reg_hit(wb_adr_i, mult_pkg::OFF_OPND_B)) begin
      next_rdata[mult_pkg::WIDE_W-1:0] = b_mul;
    end else if (reg_hit(wb_adr_i, mult_pkg::OFF_COUNT)) begin
      next_rdata = accept_cnt;
    end
  end

  // Data is captured with the acknowledge so it holds steady while ack is high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule

// ===== design/mult_pkg.sv
// Shared constants, register map and carrier types of the embedded multiplier block.
package mult_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Datapath widths.
  localparam int unsigned WIDE_W   = 18;
  localparam int unsigned NARROW_W = 9;
  localparam int unsigned PROD_W   = 36;
  localparam int unsigned SECT_W   = 18;
  localparam int unsigned N_SECT   = 2;
  localparam int unsigned CNT_W    = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus widths and word offsets (byte addresses).
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_PROD_LO = 8'h08;
  localparam logic [7:0] OFF_PROD_HI = 8'h0c;
  localparam logic [7:0] OFF_OPND_A  = 8'h10;
  localparam logic [7:0] OFF_OPND_B  = 8'h14;
  localparam logic [7:0] OFF_COUNT   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register field positions, all in byte lane 0.
  localparam int unsigned CTRL_DUAL_BIT   = 0;
  localparam int unsigned CTRL_A_REG_BIT  = 1;
  localparam int unsigned CTRL_B_REG_BIT  = 2;
  localparam int unsigned CTRL_SA_REG_BIT = 3;
  localparam int unsigned CTRL_SB_REG_BIT = 4;
  localparam int unsigned CTRL_P_REG_BIT  = 5;
  localparam int unsigned CTRL_SIGN_BIT   = 6;
  localparam int unsigned CTRL_W          = 7;
  localparam logic [6:0]  CTRL_RESET      = 7'h00;

  // Status register field positions.
  localparam int unsigned STAT_DUAL_BIT = 0;
  localparam int unsigned STAT_SA_BIT   = 1;
  localparam int unsigned STAT_SB_BIT   = 2;
  localparam int unsigned STAT_PS_BIT   = 3;
  localparam int unsigned STAT_ACLR_BIT = 4;

  // Configuration carried from the register file to the datapath.
  typedef struct packed {
    logic sign_use;
    logic p_reg;
    logic sb_reg;
    logic sa_reg;
    logic b_reg;
    logic a_reg;
    logic dual;
  } cfg_t;

  // One operand side: data and its sign select.
  typedef struct packed {
    logic              sign;
    logic [WIDE_W-1:0] data;
  } opnd_t;

endpackage

// ===== design/operand_stage.sv
// Register-or-bypass stage with clock enable and asynchronous clear.
`timescale 1ns/100ps
module operand_stage #(
  parameter int unsigned W = 18
) (
  input  wire logic         clk_i,
  input  wire logic         ena_i,
  input  wire logic         aclr_i,
  input  wire logic         use_reg_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] held;

  // The enable is a hold mux rather than a gated clock, so the register sees every edge.
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      held <= '0;
    end else begin
      held <= ena_i ? d_i : held;
    end
  end

  // Bypass is purely combinational, so a bypassed input reaches the product in the same cycle.
  assign q_o = use_reg_i ? held : d_i;

endmodule

// ===== design/mul_core.sv
// Combinational multiplier stage: one 18 by 18 or two 9 by 9 full-precision products.
`timescale 1ns/100ps
module mul_core (
  input  wire logic                        dual_i,
  input  wire logic                        sign_a_i,
  input  wire logic                        sign_b_i,
  input  wire logic [mult_pkg::WIDE_W-1:0] a_i,
  input  wire logic [mult_pkg::WIDE_W-1:0] b_i,
  output logic      [mult_pkg::PROD_W-1:0] prod_o
);

  logic signed [18:0] ext_a;
  logic signed [18:0] ext_b;
  logic signed [37:0] wide_p;
  logic signed [9:0]  lo_a;
  logic signed [9:0]  lo_b;
  logic signed [9:0]  hi_a;
  logic signed [9:0]  hi_b;
  logic signed [19:0] lo_p;
  logic signed [19:0] hi_p;

  // One extra bit carries the sign or a zero, so every sign mix multiplies without overflow.
  assign ext_a  = {sign_a_i & a_i[17], a_i};
  assign ext_b  = {sign_b_i & b_i[17], b_i};
  assign wide_p = ext_a * ext_b;

  // Both narrow products share the same two sign selects.
  assign lo_a = {sign_a_i & a_i[8], a_i[8:0]};
  assign lo_b = {sign_b_i & b_i[8], b_i[8:0]};
  assign hi_a = {sign_a_i & a_i[17], a_i[17:9]};
  assign hi_b = {sign_b_i & b_i[17], b_i[17:9]};
  assign lo_p = lo_a * lo_b;
  assign hi_p = hi_a * hi_b;

  // No bits are lost: the dropped top bits only repeat the sign.
  assign prod_o = dual_i ? {hi_p[17:0], lo_p[17:0]} : wide_p[35:0];

endmodule

// ===== dv/mult_ref.svh
// Reference product of the multiplier block, shared by the bench and its checker.
// It is included at file scope, so one compilation unit holds a single copy for both users.
`ifndef MULT_REF_SVH
`define MULT_REF_SVH
function automatic logic [35:0] ref_prod(input logic [17:0] a, input logic [17:0] b,
                                         input logic sa, input logic sb, input logic dual);
  logic signed [36:0] x;
  logic signed [36:0] y;
  logic signed [18:0] p0;
  logic signed [18:0] q0;
  logic signed [18:0] p1;
  logic signed [18:0] q1;
  // Extension by the sign select keeps the product exact in every sign pairing.
  x  = {{19{sa & a[17]}}, a};
  y  = {{19{sb & b[17]}}, b};
  p0 = {{10{sa & a[8]}}, a[8:0]};
  q0 = {{10{sb & b[8]}}, b[8:0]};
  p1 = {{10{sa & a[17]}}, a[17:9]};
  q1 = {{10{sb & b[17]}}, b[17:9]};
  if (dual) begin
    return {18'(p1 * q1), 18'(p0 * q0)};
  end
  return 36'(x * y);
endfunction
`endif

// ===== dv/fabric_src.sv
// Model of the fabric logic that launches operand pairs into the multiplier block.
`timescale 1ns/100ps
module fabric_src (
  input  wire logic            clk_i,
  input  wire logic            load_i,
  input  wire mult_pkg::opnd_t a_i,
  input  wire mult_pkg::opnd_t b_i,
  output logic [17:0]          data_a_o,
  output logic [17:0]          data_b_o,
  output logic                 sign_a_o,
  output logic                 sign_b_o
);
  // Operands leave fabric registers on a clock edge; one sign per side covers both halves.
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      data_a_o <= a_i.data;
      data_b_o <= b_i.data;
      sign_a_o <= a_i.sign;
      sign_b_o <= b_i.sign;
    end
  end
endmodule

// ===== dv/mult_chk.sv
// Port checker of the embedded multiplier block, bound from the bench top.
`timescale 1ns/100ps
`include "mult_ref.svh"
module mult_chk (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        ena_i,
  input wire logic                        aclr_i,
  input wire logic [mult_pkg::WIDE_W-1:0] data_a_i,
  input wire logic [mult_pkg::WIDE_W-1:0] data_b_i,
  input wire logic                        sign_a_i,
  input wire logic                        sign_b_i,
  input wire logic [mult_pkg::PROD_W-1:0] prod_o,
  input wire logic                        prod_signed_o,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [mult_pkg::ADR_W-1:0]  wb_adr_i,
  input wire logic [mult_pkg::SEL_W-1:0]  wb_sel_i,
  input wire logic [mult_pkg::DAT_W-1:0]  wb_dat_i,
  input wire logic                        wb_ack_o
);
  mult_pkg::cfg_t cfg;
  logic           comb;
  logic           half;
  logic           full;
  logic           su;

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the control register, rebuilt from acknowledged bus writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= mult_pkg::cfg_t'(mult_pkg::CTRL_RESET);
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                 wb_adr_i[7:2] == mult_pkg::OFF_CTRL[7:2]) begin
      cfg <= mult_pkg::cfg_t'(wb_dat_i[6:0]);
    end
  end

  // Stage arrangements that the properties below know how to predict.
  assign comb = !(cfg.a_reg || cfg.b_reg || cfg.sa_reg || cfg.sb_reg || cfg.p_reg);
  assign half = cfg.a_reg && cfg.sa_reg && !cfg.b_reg && !cfg.sb_reg && !cfg.p_reg;
  assign full = cfg.a_reg && cfg.b_reg && cfg.sa_reg && cfg.sb_reg && cfg.p_reg;
  assign su   = cfg.sign_use;

  ////////////////////////////////////////////////////////////////////////////////
  // Everything here lives in the one clock domain and sleeps through reset.
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged on the next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  AST_WIDE_COMB: assert property (comb && !cfg.dual |->
    prod_o == ref_prod(data_a_i, data_b_i, su & sign_a_i, su & sign_b_i, 1'b0))
    else $error("wide bypassed product wrong");
  AST_DUAL_COMB: assert property (comb && cfg.dual |->
    prod_o == ref_prod(data_a_i, data_b_i, su & sign_a_i, su & sign_b_i, 1'b1))
    else $error("dual bypassed products wrong");
  AST_SIGN_FLAG: assert property (comb |->
    prod_signed_o == (su & (sign_a_i | sign_b_i)))
    else $error("product sign flag wrong");
  AST_HALF_REG: assert property (half && ena_i && !aclr_i && !wb_ack_o ##1 !aclr_i |->
    prod_o == ref_prod($past(data_a_i), data_b_i, su & $past(sign_a_i), su & sign_b_i,
                       cfg.dual))
    else $error("registered A with direct B gave wrong product");
  AST_PIPE2: assert property (full && ena_i && !aclr_i && !wb_ack_o ##1
    ena_i && !aclr_i && !wb_ack_o ##1 !aclr_i |-> prod_o == ref_prod($past(data_a_i, 2),
    $past(data_b_i, 2), su & $past(sign_a_i, 2), su & $past(sign_b_i, 2), cfg.dual))
    else $error("two-stage product wrong");
  AST_HOLD: assert property (cfg.p_reg && !ena_i && !aclr_i && !wb_ack_o ##1 !aclr_i
    |-> $stable(prod_o) && $stable(prod_signed_o))
    else $error("product register moved without clock enable");
  AST_ACLR: assert property (aclr_i && (cfg.p_reg || cfg.a_reg || cfg.b_reg) |->
    prod_o == 36'h0)
    else $error("clear did not zero the product");
endmodule

// ===== dv/tb.sv
// Self-checking bench of the embedded multiplier block with its fabric-side source.
`timescale 1ns/100ps
`include "mult_ref.svh"
module tb;
  logic            clk_i, rst_i, ena_i, aclr_i, load, cyc, stb, we, ack, sa, sb, psig;
  logic [17:0]     da, db;
  logic [35:0]     prod;
  logic [7:0]      adr;
  logic [3:0]      sel;
  logic [31:0]     wdat, rdat, q;
  mult_pkg::opnd_t opa, opb;
  int              n_fail, checks, cycles;

  fabric_src src (.clk_i(clk_i), .load_i(load), .a_i(opa), .b_i(opb),
                  .data_a_o(da), .data_b_o(db), .sign_a_o(sa), .sign_b_o(sb));
  embedded_multiplier_block DUT (.clk_i(clk_i), .rst_i(rst_i), .ena_i(ena_i), .aclr_i(aclr_i),
    .data_a_i(da), .data_b_i(db), .sign_a_i(sa), .sign_b_i(sb), .prod_o(prod),
    .prod_signed_o(psig), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling well above the fewer than one hundred cycles the run needs.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; a lost acknowledge ends the wait and counts as a mismatch.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (k >= 20) n_fail++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, 4'hf, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 4'hf, 32'h0, q);
    cmp(36'(q), 36'(exp));
  endtask

  // The fabric registers the pair first, so the new operands stand one edge later.
  task automatic launch(input logic [17:0] a, input logic [17:0] b, input logic s_a,
                        input logic s_b);
    opa <= {s_a, a};
    opb <= {s_b, b};
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Control reset value, masked write, and an unmapped place that reads zero.
  task automatic t_regs();
    rd(mult_pkg::OFF_CTRL, 32'h0);
    xfer(1'b1, mult_pkg::OFF_CTRL, 4'h0, 32'h7f, q);
    rd(mult_pkg::OFF_CTRL, 32'h0);
    wr(8'h1c, 32'hff);
    rd(8'h1c, 32'h0);
  endtask

  // Bypassed wide mode through all sign pairings, then signs ignored when unused.
  task automatic t_wide();
    wr(mult_pkg::OFF_CTRL, 32'h40);
    for (int s = 0; s < 4; s++) begin
      launch(18'h3ffff, 18'h20001, s[1], s[0]);
      cmp(prod, ref_prod(18'h3ffff, 18'h20001, s[1], s[0], 1'b0));
      cmp(36'(psig), 36'(s != 0));
    end
    launch(18'h3f800, 18'h007ff, 1'b1, 1'b0);
    cmp(prod, ref_prod(18'h3f800, 18'h007ff, 1'b1, 1'b0, 1'b0));
    wr(mult_pkg::OFF_CTRL, 32'h00);
    launch(18'h3ffff, 18'h20001, 1'b1, 1'b1);
    cmp(prod, ref_prod(18'h3ffff, 18'h20001, 1'b0, 1'b0, 1'b0));
  endtask

  // Two narrow products side by side, each side under its one sign select.
  task automatic t_dual();
    wr(mult_pkg::OFF_CTRL, 32'h41);
    for (int s = 0; s < 4; s++) begin
      launch({9'h1ff, 9'h100}, {9'h0ff, 9'h1ff}, s[1], s[0]);
      cmp(prod, ref_prod({9'h1ff, 9'h100}, {9'h0ff, 9'h1ff}, s[1], s[0], 1'b1));
    end
  endtask

  // A and its sign registered, B direct: for one cycle the old A meets the new B.
  task automatic t_half();
    wr(mult_pkg::OFF_CTRL, 32'h4a);
    ena_i <= 1'b1;
    launch(18'h20003, 18'h00005, 1'b1, 1'b0);
    @(posedge clk_i);
    cmp(prod, ref_prod(18'h20003, 18'h00005, 1'b1, 1'b0, 1'b0));
    // Sampled at the falling edge, where the direct B has moved and the held A has not.
    opa <= {1'b0, 18'h00007};
    opb <= {1'b1, 18'h3fff0};
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    @(negedge clk_i);
    cmp(prod, ref_prod(18'h20003, 18'h3fff0, 1'b1, 1'b1, 1'b0));
    @(negedge clk_i);
    cmp(prod, ref_prod(18'h00007, 18'h3fff0, 1'b0, 1'b1, 1'b0));
    @(posedge clk_i);
  endtask

  // Full pipeline: two edges of latency, hold without enable, bus view, then clear.
  task automatic t_pipe();
    logic [35:0] exp;
    exp = ref_prod(18'h3fffe, 18'h1ffff, 1'b1, 1'b1, 1'b0);
    wr(mult_pkg::OFF_CTRL, 32'h7e);
    launch(18'h3fffe, 18'h1ffff, 1'b1, 1'b1);
    repeat (2) @(posedge clk_i);
    cmp(prod, exp);
    cmp(36'(psig), 36'h1);
    ena_i <= 1'b0;
    launch(18'h00001, 18'h00001, 1'b0, 1'b0);
    @(posedge clk_i);
    cmp(prod, exp);
    rd(mult_pkg::OFF_PROD_LO, exp[31:0]);
    rd(mult_pkg::OFF_PROD_HI, {28'h0, exp[35:32]});
    aclr_i <= 1'b1;
    @(posedge clk_i);
    cmp(prod, 36'h0);
    cmp(36'(psig), 36'h0);
    aclr_i <= 1'b0;
    rd(mult_pkg::OFF_OPND_A, 32'h0);
    rd(mult_pkg::OFF_COUNT, 32'h0);
    xfer(1'b0, mult_pkg::OFF_STATUS, 4'hf, 32'h0, q);
    cmp(36'(q[mult_pkg::STAT_ACLR_BIT]), 36'h1);
    xfer(1'b1, mult_pkg::OFF_STATUS, 4'h1, 32'h10, q);
    xfer(1'b0, mult_pkg::OFF_STATUS, 4'hf, 32'h0, q);
    cmp(36'(q[mult_pkg::STAT_ACLR_BIT]), 36'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clear first so every register starts known, then hold reset for three cycles.
  initial begin
    {clk_i, rst_i, aclr_i, load, ena_i, cyc, stb, we} = 8'h70;
    {adr, sel, wdat, opa, opb} = '0;
    {n_fail, checks, cycles} = '0;
    @(posedge clk_i);
    aclr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    load <= 1'b0;
    t_regs();
    t_wide();
    t_dual();
    t_half();
    t_pipe();
    conclude();
  end
endmodule

bind embedded_multiplier_block mult_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ena_i(ena_i),
  .aclr_i(aclr_i), .data_a_i(data_a_i), .data_b_i(data_b_i), .sign_a_i(sign_a_i),
  .sign_b_i(sign_b_i), .prod_o(prod_o), .prod_signed_o(prod_signed_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o));
